// [include/tcd_map.vh]
`ifndef TCD_MAP_VH
`define TCD_MAP_VH
// Two-wire device addresses (8-bit form, write)
`define TCD_ADDR_BASE 8'ha0
`define TCD_ADDR_DIAG 8'ha2
// Diagnostic control/status byte
`define TCD_CTRL_OFFSET 8'h6e
`define TCD_BIT_DISABLE_STATE 7
`define TCD_BIT_SOFT_DISABLE 6
`define TCD_BIT_FAULT 2
`define TCD_BIT_SIGNAL_LOST 1
`define TCD_CTRL_RESET 8'h00
// Monitor byte offsets (temperature, supply, bias, tx power, rx power; msb first)
`define TCD_MON_TEMP 8'h60
`define TCD_MON_VCC 8'h62
`define TCD_MON_BIAS 8'h64
`define TCD_MON_TXPWR 8'h66
`define TCD_MON_RXPWR 8'h68
`endif

// [hdl/tcd_top.v]
// Operation
// - Rate-select pin and bit are ignored; all rates work without selection.
// - Two-wire slave answers at 0xA0 with 256-byte identification memory.
// - Two-wire slave answers at 0xA2 with separate 256-byte diagnostic memory.
// - Framing follows standard small two-wire serial EEPROM protocol.
// - Diagnostic memory shows live temperature, supply, bias, tx and rx power.
// - Transmit-off input high shuts optical output; low transmits normally.
// - Toggling transmit-off input clears the transmitter fault state.
// - Undriven transmit-off input counts as asserted.
// - Host writes diagnostic byte 110 bit 6 to request shutdown.
// - Diagnostic byte 110 bit 7 reports transmit-off state.
// - Transmitter disabled when soft bit OR pin asserted.
// - Transmit-off and loss-of-signal status mirrored into diagnostic memory.
// - Laser fault disables laser, latches fault output until toggle or power cycle.
// - Byte 110 bit 2 reflects latched transmitter fault.
// - Loss-of-signal output follows input quality, mirrored in byte 110 bit 1.
`timescale 1ns/1ps
`include "tcd_map.vh"
module tcd_top #(
    parameter BASE_WORDS = 256
) (
    input wire clock_in,
    input wire reset_n_in,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_out,
    input wire tx_off_in,
    input wire tx_off_driven_in,
    input wire rate_select_in,
    input wire laser_fault_in,
    input wire receive_signal_lost_in,
    input wire [15:0] temp_in,
    input wire [15:0] vcc_in,
    input wire [15:0] bias_in,
    input wire [15:0] tx_power_in,
    input wire [15:0] rx_power_in,
    output reg laser_enable_out,
    output reg tx_fault_out,
    output reg receive_signal_lost_out
);
    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    // Per input: three stages, a change counts once stages two and three agree
    reg [2:0] s_scl, s_sda, s_off, s_flt, s_los;
    reg scl, sda, off_pin, flt, los;
    always @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_scl <= 3'h7;
            s_sda <= 3'h7;
            s_off <= 3'h7;
            s_flt <= 3'h0;
            s_los <= 3'h7;
            scl <= 1'b1;
            sda <= 1'b1;
            off_pin <= 1'b1;
            flt <= 1'b0;
            los <= 1'b1;
        end
        else
        begin
            s_scl <= {s_scl[1:0], scl_in};
            s_sda <= {s_sda[1:0], sda_in};
            // Undriven pin reads as asserted, like a pull-up
            s_off <= {s_off[1:0], tx_off_in | ~tx_off_driven_in};
            s_flt <= {s_flt[1:0], laser_fault_in};
            s_los <= {s_los[1:0], receive_signal_lost_in};
            if (s_scl[2] == s_scl[1]) scl <= s_scl[2];
            if (s_sda[2] == s_sda[1]) sda <= s_sda[2];
            if (s_off[2] == s_off[1]) off_pin <= s_off[2];
            if (s_flt[2] == s_flt[1]) flt <= s_flt[2];
            if (s_los[2] == s_los[1]) los <= s_los[2];
        end
    end

    // ------------------------------------------------------------
    // Transmit control and fault latch
    // ------------------------------------------------------------
    reg soft_off;
    reg fault;
    reg off_pin_q;
    wire off_eff = off_pin | soft_off;
    wire next_fault = fault ? ~(off_pin & ~off_pin_q) : flt;
    // rate_select_in deliberately unused
    always @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            off_pin_q <= 1'b1;
            fault <= 1'b0;
            laser_enable_out <= 1'b0;
            tx_fault_out <= 1'b0;
            receive_signal_lost_out <= 1'b1;
        end
        else
        begin
            off_pin_q <= off_pin;
            // Rising edge of the pin (a toggle) clears; a new fault wins
            fault <= next_fault | flt;
            laser_enable_out <= ~off_eff & ~(next_fault | flt);
            tx_fault_out <= next_fault | flt;
            receive_signal_lost_out <= los;
        end
    end

    wire [7:0] ctrl_byte = {off_eff, soft_off, 3'h0, fault, los, 1'b0};

    // ------------------------------------------------------------
    // Two-wire EEPROM-style slave
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_DEV = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_WR = 3'h3;
    localparam ST_RD = 3'h4;
    localparam ST_RACK = 3'h5;

    reg [2:0] state;
    reg scl_q, sda_q;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] ptr;
    reg diag_sel;
    reg reading;
    reg have_ptr;
    reg [7:0] base_mem [0:BASE_WORDS-1];
    reg [7:0] diag_mem [0:255];

    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_c = scl & scl_q & sda_q & ~sda;
    wire stop_c = scl & scl_q & ~sda_q & sda;

    // Read data: live monitors and control byte overlay the store
    reg [7:0] rd_byte;
    always @*
    begin
        rd_byte = diag_sel ? diag_mem[ptr] : base_mem[ptr];
        if (diag_sel)
        begin
            case (ptr)
                `TCD_MON_TEMP: rd_byte = temp_in[15:8];
                `TCD_MON_TEMP + 8'h01: rd_byte = temp_in[7:0];
                `TCD_MON_VCC: rd_byte = vcc_in[15:8];
                `TCD_MON_VCC + 8'h01: rd_byte = vcc_in[7:0];
                `TCD_MON_BIAS: rd_byte = bias_in[15:8];
                `TCD_MON_BIAS + 8'h01: rd_byte = bias_in[7:0];
                `TCD_MON_TXPWR: rd_byte = tx_power_in[15:8];
                `TCD_MON_TXPWR + 8'h01: rd_byte = tx_power_in[7:0];
                `TCD_MON_RXPWR: rd_byte = rx_power_in[15:8];
                `TCD_MON_RXPWR + 8'h01: rd_byte = rx_power_in[7:0];
                `TCD_CTRL_OFFSET: rd_byte = ctrl_byte;
                default: rd_byte = diag_mem[ptr];
            endcase
        end
    end

    integer i;
    always @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            diag_sel <= 1'b0;
            reading <= 1'b0;
            have_ptr <= 1'b0;
            soft_off <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            for (i = 0; i < BASE_WORDS; i = i + 1)
                base_mem[i] <= 8'h00;
            for (i = 0; i < 256; i = i + 1)
                diag_mem[i] <= 8'h00;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            sda_out <= 1'b0;
            if (start_c)
            begin
                state <= ST_DEV;
                bit_cnt <= 4'h0;
                sda_oe_out <= 1'b0;
            end
            else if (stop_c)
            begin
                state <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_DEV, ST_WR:
                    begin
                        if (scl_rise)
                        begin
                            shreg <= {shreg[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (scl_fall && bit_cnt == 4'h8)
                        begin
                            bit_cnt <= 4'h0;
                            if (state == ST_DEV)
                            begin
                                if ({shreg[7:1], 1'b0} == `TCD_ADDR_BASE ||
                                    {shreg[7:1], 1'b0} == `TCD_ADDR_DIAG)
                                begin
                                    diag_sel <= shreg[1];
                                    reading <= shreg[0];
                                    have_ptr <= 1'b0;
                                    sda_oe_out <= 1'b1;
                                    state <= ST_ACK;
                                end
                                else
                                    state <= ST_IDLE;
                            end
                            else
                            begin
                                if (!have_ptr)
                                begin
                                    ptr <= shreg;
                                    have_ptr <= 1'b1;
                                end
                                else
                                begin
                                    if (diag_sel && ptr == `TCD_CTRL_OFFSET)
                                        soft_off <= shreg[`TCD_BIT_SOFT_DISABLE];
                                    else if (diag_sel)
                                        diag_mem[ptr] <= shreg;
                                    else
                                        base_mem[ptr] <= shreg;
                                    ptr <= ptr + 8'h01;
                                end
                                sda_oe_out <= 1'b1;
                                state <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK:
                        if (scl_fall)
                        begin
                            if (reading)
                            begin
                                shreg <= {rd_byte[6:0], 1'b0};
                                sda_oe_out <= ~rd_byte[7];
                                bit_cnt <= 4'h1;
                                ptr <= ptr + 8'h01;
                                state <= ST_RD;
                            end
                            else
                            begin
                                sda_oe_out <= 1'b0;
                                state <= ST_WR;
                            end
                        end
                    ST_RD:
                        if (scl_fall)
                        begin
                            if (bit_cnt == 4'h8)
                            begin
                                sda_oe_out <= 1'b0;
                                state <= ST_RACK;
                            end
                            else
                            begin
                                sda_oe_out <= ~shreg[7];
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    ST_RACK:
                        if (scl_rise)
                            state <= sda ? ST_IDLE : ST_ACK;
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // tcd_top

// [test/tcd_chk.sv]
`timescale 1ns/1ps
module tcd_chk (
    input wire clock_in,
    input wire reset_n_in,
    input wire scl_in,
    input wire sda_oe_out,
    input wire tx_off_in,
    input wire tx_off_driven_in,
    input wire laser_fault_in,
    input wire receive_signal_lost_in,
    input wire laser_enable_out,
    input wire tx_fault_out,
    input wire receive_signal_lost_out
);
    // ----
    // Pins settle after reset
    // ----
    reg [3:0] up;
    wire rdy = up == 4'hf;
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            up <= 4'h0;
        else if (!rdy)
            up <= up + 4'h1;
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);
    a_pin_off: assert property ((rdy && tx_off_in) [*8] |-> !laser_enable_out)
        else $error("laser on");
    a_float_off: assert property ((rdy && !tx_off_driven_in) [*8] |-> !laser_enable_out)
        else $error("laser on");
    a_fault_set: assert property ((rdy && laser_fault_in) [*8] |-> tx_fault_out && !laser_enable_out)
        else $error("no fault");
    a_fault_hold: assert property ((rdy && tx_fault_out && tx_off_driven_in && !tx_off_in) [*8] |=> tx_fault_out)
        else $error("fault lost");
    a_fault_clear: assert property ((rdy && tx_off_driven_in && !laser_fault_in) [*8] ##0 $rose(tx_off_in)
        ##1 (tx_off_in && tx_off_driven_in && !laser_fault_in) [*8] |-> !tx_fault_out) else $error("fault kept");
    a_los_follow: assert property ((rdy && $stable(receive_signal_lost_in)) [*8]
        |-> receive_signal_lost_out == receive_signal_lost_in) else $error("los");
    a_sda_hold: assert property ($fell(scl_in) |-> $stable(sda_oe_out) [*2]) else $error("sda hold");
    a_sda_move: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("sda move");
    c_fault: cover property (tx_fault_out ##1 !tx_fault_out);
    c_ack: cover property ($rose(sda_oe_out));
    c_float: cover property (rdy && !tx_off_driven_in);
endmodule // tcd_chk
bind tcd_top tcd_chk u_chk (.clock_in, .reset_n_in, .scl_in, .sda_oe_out, .tx_off_in, .tx_off_driven_in,
    .laser_fault_in, .receive_signal_lost_in, .laser_enable_out, .tx_fault_out, .receive_signal_lost_out);

// [test/tcd_host.sv]
`timescale 1ns/1ps
module tcd_host (
    input wire clock_in,
    input wire sda_in,
    output reg scl_out = 1'b1,
    output reg sda_pull_out = 1'b0
);
    // ----
    // Two-wire master, idle high
    // ----
    task automatic drv(input logic c, input logic p);
        scl_out <= c;
        sda_pull_out <= p;
        repeat (5) @(posedge clock_in);
    endtask
    task automatic cond(input logic [3:0] c, input logic [3:0] p);
        for (int i = 3; i >= 0; i--)
            drv(c[i], p[i]);
    endtask
    task automatic put_bit(input logic b, output logic got);
        drv(1'b0, !b);
        drv(1'b1, !b);
        got = sda_in;
        drv(1'b1, !b);
        drv(1'b0, !b);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], q[i]);
        put_bit(ak, a);
    endtask
    task automatic acc(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] dat, input logic two,
            output logic [7:0] q, output logic a);
        logic [7:0] x;
        logic y;
        cond(4'b0110, 4'b0011);
        xfer({dev[7:1], 1'b0}, 1'b1, x, a);
        xfer(ptr, 1'b1, x, y);
        if (dev[0])
        begin
            cond(4'b0110, 4'b0011);
            xfer(dev, 1'b1, x, y);
            // Ack the first byte so the device moves on to the next offset
            if (two)
                xfer(8'hff, 1'b0, x, y);
            xfer(8'hff, 1'b1, q, y);
        end
        else
            xfer(dat, 1'b1, q, y);
        cond(4'b0111, 4'b1100);
    endtask
endmodule // tcd_host

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    reg clock_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg tx_off_in = 1'b0;
    reg tx_off_driven_in = 1'b0;
    reg rate_select_in = 1'b0;
    reg laser_fault_in = 1'b0;
    reg receive_signal_lost_in = 1'b1;
    reg [15:0] mv = 16'h0;
    logic [15:0] e;
    logic [7:0] q;
    logic a;
    wire scl_in, pull, sda_out, sda_oe_out, laser_enable_out, tx_fault_out, receive_signal_lost_out;
    // Open drain with pull-up: the module only ever pulls to its own output level
    wire sda_in = ~pull & (sda_oe_out ? sda_out : 1'b1);
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    always #12.5 clock_in = ~clock_in;
    tcd_top u_dut (.clock_in, .reset_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .tx_off_in,
        .tx_off_driven_in, .rate_select_in, .laser_fault_in, .receive_signal_lost_in, .temp_in(mv),
        .vcc_in(mv + 16'h1), .bias_in(mv + 16'h2), .tx_power_in(mv + 16'h3), .rx_power_in(mv + 16'h4),
        .laser_enable_out, .tx_fault_out, .receive_signal_lost_out);
    tcd_host u_host (.clock_in, .sda_in, .scl_out(scl_in), .sda_pull_out(pull));
    // ----
    // Checks and bus access
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] dev, input logic [7:0] ptr, input logic [8:0] exp);
        u_host.acc(dev | 8'h01, ptr, 8'h00, 1'b0, q, a);
        chk({a, q}, exp);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
        u_host.acc(8'ha2, ptr, dat, 1'b0, q, a);
        chk(a, 1'b0);
    endtask
    task automatic pins(input logic [3:0] v, input logic [2:0] exp);
        {tx_off_driven_in, tx_off_in, laser_fault_in, receive_signal_lost_in} <= v;
        repeat (12) @(posedge clock_in);
        chk({laser_enable_out, tx_fault_out, receive_signal_lost_out}, exp);
    endtask
    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (12) @(posedge clock_in);
        reset_n_in <= 1'b1;
        repeat (12) @(posedge clock_in);
        pins(4'b0001, 3'b001);
        rd(8'ha2, 8'h6e, 9'h082);
        pins(4'b1000, 3'b100);
        rate_select_in <= 1'b1;
        pins(4'b1000, 3'b100);
        rd(8'ha2, 8'h6e, 9'h000);
        wr(8'h6e, 8'hff);
        rd(8'ha2, 8'h6e, 9'h0c0);
        pins(4'b1000, 3'b000);
        wr(8'h6e, 8'h00);
        pins(4'b1000, 3'b100);
        wr(8'h10, 8'h5a);
        rd(8'ha0, 8'h10, 9'h000);
        rd(8'ha2, 8'h10, 9'h05a);
        rd(8'ha4, 8'h00, 9'h1ff);
        // Sequential read: first byte acked, second byte comes from the next offset
        u_host.acc(8'ha3, 8'h0f, 8'h00, 1'b1, q, a);
        chk({a, q}, 9'h05a);
        mv <= 16'hc35a;
        for (int k = 0; k < 10; k++)
        begin
            e = 16'hc35a + 16'(k / 2);
            rd(8'ha2, 8'h60 + 8'(k), {1'b0, k[0] ? e[7:0] : e[15:8]});
        end
        mv <= 16'h0f0f;
        rd(8'ha2, 8'h61, 9'h00f);
        pins(4'b1010, 3'b010);
        rd(8'ha2, 8'h6e, 9'h004);
        pins(4'b1000, 3'b010);
        pins(4'b1100, 3'b000);
        pins(4'b1000, 3'b100);
        pins(4'b1001, 3'b101);
        rd(8'ha2, 8'h6e, 9'h002);
        complete_run();
    end
endmodule // tb_top
